// file: core/flash_host_pkg.sv
/*
 * Shared constants for the flash programming controller: command bytes,
 * bus phase lengths and pulse timing.
 * Assumes a 100 MHz clock; every cycle count is derived from a time in its own unit.
 */
`default_nettype none
package flash_host_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CNT_W = 24;
   // command bytes written into the device command latch, then the erased and pre-program data values
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_IDENT = 8'h90;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
   localparam logic [7:0] CMD_PROG = 8'h40;
   localparam logic [7:0] CMD_PROG_VERIFY = 8'hC0;
   localparam logic [7:0] CMD_RESET = 8'hFF;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] PREPROG_BYTE = 8'h00;
   // user operation codes
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_IDENT = 3'h1;
   localparam logic [2:0] OP_PROG = 3'h2;
   localparam logic [2:0] OP_ERASE = 3'h3;
   localparam logic [2:0] OP_ABORT = 3'h4;
   // pulse and settle times, least times rounded up
   localparam int PROG_PULSE_US = 10;
   localparam int PROG_PULSE_CYC = (PROG_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int VERIFY_DELAY_US = 6;
   localparam int VERIFY_CYC = (VERIFY_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int VPP_RAMP_US = 1;
   localparam int VPP_RAMP_CYC = (VPP_RAMP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERASE_PULSE_US = 10000;
   localparam int ERASE_PULSE_CYC = (ERASE_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // strobe phases of one bus cycle, then the program and erase pulse limits
   localparam int SETUP_NS = 20;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_LOW_NS = 100;
   localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_NS = 20;
   localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_NS = 150;
   localparam int READ_CYC = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PROG_PULSES_MAX = 25;
   localparam int ERASE_PULSES_MAX = 1000;
endpackage
`default_nettype wire

// file: core/flash_prog_host.sv
/*
 * Host-side controller that programs, erases, identifies and reads a
 * byte-wide flash part through its parallel pins and command latch.
 * Assumes the part sits on mem_addr/dq with active-low ce_n, we_n, oe_n,
 * and that vpp_high switches the programming supply.
 */
`default_nettype none
module flash_prog_host #(
   parameter int ADDR_W = 18,
   parameter int PROG_MAX = flash_host_pkg::PROG_PULSES_MAX,
   parameter int ERASE_MAX = flash_host_pkg::ERASE_PULSES_MAX,
   parameter int ERASE_CYC = flash_host_pkg::ERASE_PULSE_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic op_start,
   input wire logic [2:0] op_code,
   input wire logic [ADDR_W-1:0] op_addr,
   input wire logic [7:0] op_data,
   output logic busy,
   output logic done,
   output logic fail,
   output logic [7:0] rd_data,
   output logic [ADDR_W-1:0] mem_addr,
   input wire logic [7:0] dq_in,
   output logic [7:0] dq_out,
   output logic dq_oe,
   output logic ce_n,
   output logic we_n,
   output logic oe_n,
   output logic vpp_high
);
   localparam int CW = flash_host_pkg::CNT_W;
   localparam int PW = $clog2(PROG_MAX + 1);
   localparam int EW = $clog2(ERASE_MAX + 1);
   localparam logic [ADDR_W-1:0] LAST_ADDR = '1;
   localparam logic [ADDR_W-1:0] ADDR_ONE = {{(ADDR_W-1){1'b0}}, 1'b1};

   typedef enum logic [4:0] {
      ST_IDLE, ST_VUP, ST_RDCMD, ST_IDCMD, ST_XREAD,
      ST_PSET, ST_PDATA, ST_PPULSE, ST_PVCMD, ST_PVWAIT, ST_PVREAD, ST_PCHECK,
      ST_SCAN, ST_SCHECK, ST_ESET1, ST_ESET2, ST_EPULSE, ST_EVCMD, ST_EVWAIT,
      ST_EVREAD, ST_ECHECK, ST_ASET, ST_AFF1, ST_AFF2, ST_FIN, ST_DONE
   } state_t;
   typedef enum logic [2:0] {B_IDLE, B_WSET, B_WLOW, B_WHOLD, B_RWAIT} bus_t;

   logic rst_sync1_reg, rst_n;
   logic [7:0] dq_s1_reg, dq_s2_reg, dq_s3_reg;
   state_t state_reg, state_next;
   bus_t bst_reg, bst_next;
   logic [ADDR_W-1:0] addr_reg, addr_next, baddr_reg, baddr_next;
   logic [7:0] data_reg, data_next, bdata_reg, bdata_next, rd_reg, rd_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [2:0] op_reg, op_next;
   logic [PW-1:0] pulse_reg, pulse_next;
   logic [EW-1:0] epulse_reg, epulse_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic [7:0] bcnt_reg, bcnt_next;
   logic pre_reg, pre_next, busy_reg, busy_next, done_reg, done_next;
   logic fail_reg, fail_next, vpp_reg, vpp_next, issued_reg, issued_next;
   logic oe_drv_reg, oe_drv_next, ce_n_reg, ce_n_next, we_n_reg, we_n_next;
   logic oe_n_reg, oe_n_next;
   logic cyc_done_reg, cyc_done_next;

   // reset release through two flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_n <= rst_sync1_reg;
      end
   end

   // read data from the pins; first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dq_s1_reg <= 8'h00;
         dq_s2_reg <= 8'h00;
         dq_s3_reg <= 8'h00;
      end else begin
         dq_s1_reg <= dq_in;
         dq_s2_reg <= dq_s1_reg;
         dq_s3_reg <= dq_s2_reg;
      end
   end

   wire cyc_wr = state_reg inside {ST_RDCMD, ST_IDCMD, ST_PSET, ST_PDATA, ST_PVCMD,
      ST_ESET1, ST_ESET2, ST_EVCMD, ST_ASET, ST_AFF1, ST_AFF2, ST_FIN};
   wire cyc_rd = state_reg inside {ST_XREAD, ST_PVREAD, ST_SCAN, ST_EVREAD};
   wire bus_go = (cyc_wr | cyc_rd) & ~issued_reg & (bst_reg == B_IDLE);
   wire [7:0] cyc_data =
      (state_reg == ST_IDCMD) ? flash_host_pkg::CMD_IDENT :
      (state_reg == ST_PSET || state_reg == ST_ASET) ? flash_host_pkg::CMD_PROG :
      (state_reg == ST_PDATA) ? data_reg :
      (state_reg == ST_PVCMD) ? flash_host_pkg::CMD_PROG_VERIFY :
      (state_reg == ST_ESET1 || state_reg == ST_ESET2) ? flash_host_pkg::CMD_ERASE :
      (state_reg == ST_EVCMD) ? flash_host_pkg::CMD_ERASE_VERIFY :
      (state_reg == ST_AFF1 || state_reg == ST_AFF2) ? flash_host_pkg::CMD_RESET :
      flash_host_pkg::CMD_READ;
   wire [ADDR_W-1:0] cyc_addr = (state_reg inside {ST_PDATA, ST_EVCMD, ST_XREAD, ST_PVREAD,
      ST_SCAN, ST_EVREAD}) ? addr_reg : '0;
   wire cnt_zero = (cnt_reg == '0);
   wire [CW-1:0] cnt_dec = cnt_reg - {{(CW-1){1'b0}}, 1'b1};
   wire bcnt_zero = (bcnt_reg == 8'h00);
   wire [7:0] bcnt_dec = bcnt_reg - 8'h01;
   wire rd_agree = (dq_s2_reg == dq_s3_reg);
   wire at_last = (addr_reg == LAST_ADDR);
   wire [ADDR_W-1:0] addr_inc = addr_reg + ADDR_ONE;

   // strobe engine: one write or read cycle per request
   always_comb begin
      bst_next = bst_reg;
      bcnt_next = bcnt_reg;
      baddr_next = baddr_reg;
      bdata_next = bdata_reg;
      ce_n_next = ce_n_reg;
      we_n_next = we_n_reg;
      oe_n_next = oe_n_reg;
      oe_drv_next = oe_drv_reg;
      rd_next = rd_reg;
      cyc_done_next = 1'b0;
      unique case (bst_reg)
         B_IDLE: if (bus_go) begin
            baddr_next = cyc_addr;
            bdata_next = cyc_data;
            ce_n_next = 1'b0;
            if (cyc_wr) begin
               oe_drv_next = 1'b1;
               bcnt_next = 8'(flash_host_pkg::SETUP_CYC);
               bst_next = B_WSET;
            end else begin
               oe_n_next = 1'b0;
               bcnt_next = 8'(flash_host_pkg::READ_CYC);
               bst_next = B_RWAIT;
            end
         end
         B_WSET: if (bcnt_zero) begin
            we_n_next = 1'b0;
            bcnt_next = 8'(flash_host_pkg::WE_LOW_CYC);
            bst_next = B_WLOW;
         end else begin
            bcnt_next = bcnt_dec;
         end
         B_WLOW: if (bcnt_zero) begin
            we_n_next = 1'b1;
            bcnt_next = 8'(flash_host_pkg::HOLD_CYC);
            bst_next = B_WHOLD;
         end else begin
            bcnt_next = bcnt_dec;
         end
         B_WHOLD: if (bcnt_zero) begin
            ce_n_next = 1'b1;
            oe_drv_next = 1'b0;
            cyc_done_next = 1'b1;
            bst_next = B_IDLE;
         end else begin
            bcnt_next = bcnt_dec;
         end
         B_RWAIT: if (bcnt_zero && rd_agree) begin
            rd_next = dq_s3_reg;
            ce_n_next = 1'b1;
            oe_n_next = 1'b1;
            cyc_done_next = 1'b1;
            bst_next = B_IDLE;
         end else if (!bcnt_zero) begin
            bcnt_next = bcnt_dec;
         end
      endcase
   end

   // operation sequencer
   always_comb begin
      state_next = state_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      op_next = op_reg;
      pulse_next = pulse_reg;
      epulse_next = epulse_reg;
      cnt_next = cnt_reg;
      pre_next = pre_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      fail_next = fail_reg;
      rdata_next = rdata_reg;
      vpp_next = vpp_reg;
      unique case (state_reg)
         ST_IDLE: if (op_start) begin
            busy_next = 1'b1;
            vpp_next = 1'b1;
            fail_next = 1'b0;
            op_next = op_code;
            addr_next = op_addr;
            data_next = op_data;
            pulse_next = '0;
            pre_next = 1'b0;
            cnt_next = CW'(flash_host_pkg::VPP_RAMP_CYC);
            state_next = ST_VUP;
         end
         ST_VUP: if (!cnt_zero) begin
            cnt_next = cnt_dec;
         end else if (op_reg == flash_host_pkg::OP_IDENT) begin
            state_next = ST_IDCMD;
         end else if (op_reg == flash_host_pkg::OP_PROG) begin
            state_next = ST_PSET;
         end else if (op_reg == flash_host_pkg::OP_ERASE) begin
            addr_next = '0;
            state_next = ST_SCAN;
         end else if (op_reg == flash_host_pkg::OP_ABORT) begin
            state_next = ST_ASET;
         end else begin
            state_next = ST_RDCMD;
         end
         ST_RDCMD, ST_IDCMD: if (cyc_done_reg) state_next = ST_XREAD;
         ST_XREAD: if (cyc_done_reg) begin
            rdata_next = rd_reg;
            state_next = ST_FIN;
         end
         ST_PSET: if (cyc_done_reg) state_next = ST_PDATA;
         ST_PDATA: if (cyc_done_reg) begin
            pulse_next = pulse_reg + PW'(1);
            cnt_next = CW'(flash_host_pkg::PROG_PULSE_CYC);
            state_next = ST_PPULSE;
         end
         ST_PPULSE: if (cnt_zero) state_next = ST_PVCMD; else cnt_next = cnt_dec;
         ST_PVCMD: if (cyc_done_reg) begin
            cnt_next = CW'(flash_host_pkg::VERIFY_CYC);
            state_next = ST_PVWAIT;
         end
         ST_PVWAIT: if (cnt_zero) state_next = ST_PVREAD; else cnt_next = cnt_dec;
         ST_PVREAD: if (cyc_done_reg) begin
            rdata_next = rd_reg;
            state_next = ST_PCHECK;
         end
         ST_PCHECK: if (rd_reg == data_reg) begin
            pulse_next = '0;
            if (!pre_reg) begin
               state_next = ST_FIN;
            end else if (at_last) begin
               addr_next = '0;
               epulse_next = '0;
               state_next = ST_ESET1;
            end else begin
               addr_next = addr_inc;
               state_next = ST_PSET;
            end
         end else if (pulse_reg >= PW'(PROG_MAX)) begin
            fail_next = 1'b1;
            state_next = ST_FIN;
         end else begin
            state_next = ST_PSET;
         end
         ST_SCAN: if (cyc_done_reg) state_next = ST_SCHECK;
         ST_SCHECK: if (rd_reg != flash_host_pkg::ERASED_BYTE) begin
            addr_next = '0;
            data_next = flash_host_pkg::PREPROG_BYTE;
            pre_next = 1'b1;
            state_next = ST_PSET;
         end else if (at_last) begin
            state_next = ST_FIN;
         end else begin
            addr_next = addr_inc;
            state_next = ST_SCAN;
         end
         ST_ESET1: if (cyc_done_reg) state_next = ST_ESET2;
         ST_ESET2: if (cyc_done_reg) begin
            epulse_next = epulse_reg + EW'(1);
            cnt_next = CW'(ERASE_CYC);
            state_next = ST_EPULSE;
         end
         ST_EPULSE: if (cnt_zero) state_next = ST_EVCMD; else cnt_next = cnt_dec;
         ST_EVCMD: if (cyc_done_reg) begin
            cnt_next = CW'(flash_host_pkg::VERIFY_CYC);
            state_next = ST_EVWAIT;
         end
         ST_EVWAIT: if (cnt_zero) state_next = ST_EVREAD; else cnt_next = cnt_dec;
         ST_EVREAD: if (cyc_done_reg) state_next = ST_ECHECK;
         ST_ECHECK: if (rd_reg == flash_host_pkg::ERASED_BYTE) begin
            if (at_last) begin
               state_next = ST_FIN;
            end else begin
               addr_next = addr_inc;
               state_next = ST_EVCMD;
            end
         end else if (epulse_reg >= EW'(ERASE_MAX)) begin
            fail_next = 1'b1;
            state_next = ST_FIN;
         end else begin
            state_next = ST_ESET1;
         end
         ST_ASET: if (cyc_done_reg) state_next = ST_AFF1;
         ST_AFF1: if (cyc_done_reg) state_next = ST_AFF2;
         ST_AFF2: if (cyc_done_reg) state_next = ST_FIN;
         ST_FIN: if (cyc_done_reg) state_next = ST_DONE;
         ST_DONE: begin
            done_next = 1'b1;
            busy_next = 1'b0;
            vpp_next = 1'b0;
            state_next = ST_IDLE;
         end
      endcase
   end

   wire issued_set = bus_go | (issued_reg & ~cyc_done_reg);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         bst_reg <= B_IDLE;
         {addr_reg, baddr_reg} <= '0;
         {data_reg, bdata_reg, rd_reg, rdata_reg} <= 32'h00000000;
         {op_reg, pulse_reg, epulse_reg, cnt_reg, bcnt_reg} <= '0;
         {pre_reg, busy_reg, done_reg, fail_reg, vpp_reg, issued_reg} <= 6'h00;
         {oe_drv_reg, ce_n_reg, we_n_reg, oe_n_reg, cyc_done_reg} <= 5'h0E;
      end else begin
         state_reg <= state_next;
         bst_reg <= bst_next;
         {addr_reg, baddr_reg} <= {addr_next, baddr_next};
         {data_reg, bdata_reg, rd_reg, rdata_reg} <= {data_next, bdata_next, rd_next, rdata_next};
         {op_reg, pulse_reg, epulse_reg} <= {op_next, pulse_next, epulse_next};
         {cnt_reg, bcnt_reg} <= {cnt_next, bcnt_next};
         {pre_reg, busy_reg, done_reg} <= {pre_next, busy_next, done_next};
         {fail_reg, vpp_reg, issued_reg} <= {fail_next, vpp_next, issued_set};
         {oe_drv_reg, ce_n_reg, we_n_reg} <= {oe_drv_next, ce_n_next, we_n_next};
         {oe_n_reg, cyc_done_reg} <= {oe_n_next, cyc_done_next};
      end
   end

   assign busy = busy_reg;
   assign done = done_reg;
   assign fail = fail_reg;
   assign rd_data = rdata_reg;
   assign mem_addr = baddr_reg;
   assign dq_out = bdata_reg;
   assign dq_oe = oe_drv_reg;
   // strobes kept active low in their flops so the pins see no gate after them
   assign ce_n = ce_n_reg;
   assign we_n = we_n_reg;
   assign oe_n = oe_n_reg;
   assign vpp_high = vpp_reg;

   // watch logic: committed command history for the checks below
   logic we_prev_reg;
   logic [7:0] last_cmd_reg;
   logic [CW-1:0] gap_reg;
   wire we_rise = we_n & ~we_prev_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         we_prev_reg <= 1'b1;
         last_cmd_reg <= 8'h00;
         gap_reg <= '0;
      end else begin
         we_prev_reg <= we_n;
         last_cmd_reg <= we_rise ? dq_out : last_cmd_reg;
         gap_reg <= we_rise ? '0 : ((&gap_reg) ? gap_reg : gap_reg + {{(CW-1){1'b0}}, 1'b1});
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_prog_verify_commit;
      $rose(we_n) && dq_out == flash_host_pkg::CMD_PROG_VERIFY;
   endsequence
   sequence s_first_reset_commit;
      $rose(we_n) && state_reg == ST_AFF1;
   endsequence

   AST_WE_UNDER_CE: assert property (!we_n |-> !ce_n && dq_oe)
      else $error("write strobe without chip select or data drive");
   AST_WRITE_STABLE: assert property (!we_n && !$past(we_n) |->
      $stable(mem_addr) && $stable(dq_out))
      else $error("address or data moved during write strobe");
   AST_NO_CONTENTION: assert property (!oe_n |-> !dq_oe)
      else $error("host drives data while output enable low");
   AST_VPP_IN_PROGRAM: assert property (state_reg inside {ST_PSET, ST_PDATA, ST_PPULSE, ST_PVCMD,
      ST_PVWAIT, ST_PVREAD, ST_PCHECK} |-> vpp_high)
      else $error("supply dropped during program loop");
   AST_PULSE_LIMIT: assert property (pulse_reg <= PW'(PROG_MAX))
      else $error("program pulse count over limit");
   AST_PULSE_WIDTH: assert property (s_prog_verify_commit |->
      gap_reg >= CW'(flash_host_pkg::PROG_PULSE_CYC))
      else $error("program pulse shorter than minimum");
   AST_ERASE_TWICE: assert property ($rose(we_n) && state_reg == ST_ESET2 |->
      last_cmd_reg == flash_host_pkg::CMD_ERASE)
      else $error("erase start without preceding set-up");
   AST_ABORT_PAIR: assert property (s_first_reset_commit |->
      ##[1:100] ($rose(we_n) && dq_out == flash_host_pkg::CMD_RESET))
      else $error("second reset write missing");
   AST_END_ON_READ: assert property ($rose(done) |->
      last_cmd_reg == flash_host_pkg::CMD_READ && !vpp_high)
      else $error("operation ended without read command");
endmodule
`default_nettype wire

// file: verification/flash_dev_model.sv
/*
 * Behavioural byte-wide flash part for the host controller bench.
 * Assumes active-low ce_n/we_n/oe_n strobes from the host; no clock, edge driven.
 */
`default_nettype none
module flash_dev_model #(
   parameter int AW = 3,
   parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
   parameter logic [7:0] PART_ID = 8'hC3, // arbitrary value
   parameter int STOP_NS = 1000000 // stop timer length, chosen
) (
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] din,
   output logic [7:0] dout,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic vpp_high,
   input wire logic [7:0] prog_need,
   input wire logic [7:0] erase_need,
   output var int prog_cnt,
   output var int erase_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [2**AW];
   logic [7:0] cmd_reg = 8'h00;
   logic [7:0] pd = 8'h00;
   logic [7:0] val;
   logic [AW-1:0] lat_a = '0;
   logic [AW-1:0] prog_a = '0;
   logic [AW-1:0] ev_a = '0;
   logic erasing = 1'b0;
   logic programming = 1'b0;
   int st = 0;
   int hits = 0;
   realtime t_go = 0.0;
   initial begin
      prog_cnt = 0;
      erase_cnt = 0;
      foreach (mem[i]) mem[i] = 8'hFF;
   end
   always @(negedge vpp_high) begin
      cmd_reg = 8'h00;
      st = 0;
   end
   always @(negedge we_n) if (!ce_n) lat_a = addr;
   // a pulse older than the stop timer has already ended; the part then waits
   // for a verify or reset write and ignores any other
   always @(posedge we_n) if (!ce_n && vpp_high && !((erasing || programming) &&
      ($realtime - t_go > STOP_NS) && !(din inside {8'hA0, 8'hC0, 8'hFF}))) begin
      if (erasing) erase_cnt++;
      if (erasing && erase_cnt >= erase_need) foreach (mem[i]) mem[i] = 8'hFF;
      if (programming) begin
         prog_cnt++;
         hits++;
         if (hits >= prog_need) mem[prog_a] = mem[prog_a] & pd;
      end
      erasing = 1'b0;
      programming = 1'b0;
      if (st == 1 && din == 8'h20) erasing = 1'b1;
      if (st == 2 && din != 8'hFF) begin
         programming = 1'b1;
         if (lat_a != prog_a) hits = 0;
         prog_a = lat_a;
         pd = din;
      end
      if (erasing || programming) t_go = $realtime;
      if (st == 0) cmd_reg = din;
      if (st == 3) cmd_reg = 8'h00;
      if (st == 0 && din == 8'hA0) ev_a = lat_a;
      st = (st == 0 && din == 8'h20) ? 1 : (st == 0 && din == 8'h40) ? 2 :
         (st inside {1, 2} && din == 8'hFF) ? 3 : 0;
   end
   always @* begin
      case (cmd_reg)
         8'h90: val = addr[0] ? PART_ID : MAKER_ID;
         8'hA0: val = mem[ev_a];
         8'hC0: val = mem[prog_a];
         default: val = mem[addr];
      endcase
      // released bus shows a changed value, never the last one
      dout = (!ce_n && !oe_n) ? val : ~val;
   end
endmodule
`default_nettype wire

// file: verification/flash_command_state_machine_test.sv
/*
 * Self-checking bench for the flash programming controller.
 * Assumes the behavioural part in flash_dev_model on the far side.
 */
`default_nettype none
module flash_command_state_machine_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int AW = 3;
   localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
   localparam logic [7:0] PART = 8'hC3; // arbitrary value
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic op_start = 1'b0;
   logic busy, done, fail, dq_oe, ce_n, we_n, oe_n, vpp_high;
   logic [2:0] op_code = 3'h0;
   logic [AW-1:0] op_addr = '0;
   logic [AW-1:0] mem_addr;
   logic [7:0] op_data = 8'h00;
   logic [7:0] rd_data, dq_out, dev_q;
   logic [7:0] prog_need = 8'h02;
   logic [7:0] erase_need = 8'h02;
   wire logic [7:0] dq_in = dq_oe ? dq_out : dev_q;
   int prog_cnt, erase_cnt, p0, e0, a;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;
   int ref_mem [2**AW];
   logic [16:0] lfsr = 17'h12409;
   flash_prog_host #(.ADDR_W(AW), .ERASE_CYC(200)) i_flash_prog_host (
      .clk(clk), .rstn(rstn), .op_start(op_start), .op_code(op_code), .op_addr(op_addr),
      .op_data(op_data), .busy(busy), .done(done), .fail(fail), .rd_data(rd_data),
      .mem_addr(mem_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n),
      .we_n(we_n), .oe_n(oe_n), .vpp_high(vpp_high));
   flash_dev_model #(.AW(AW), .MAKER_ID(MAKER), .PART_ID(PART)) i_flash_dev_model (
      .addr(mem_addr), .din(dq_in), .dout(dev_q), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
      .vpp_high(vpp_high), .prog_need(prog_need), .erase_need(erase_need),
      .prog_cnt(prog_cnt), .erase_cnt(erase_cnt));
   initial forever #5 clk = ~clk;
   function automatic logic [16:0] lfsr_next(input logic [16:0] x);
      return {x[15:0], x[16] ^ x[13]};
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // one request, then wait for the completion pulse
   task automatic run(input logic [2:0] code, input int addr, input logic [7:0] d);
      @(negedge clk);
      op_code = code;
      op_addr = addr[AW-1:0];
      op_data = d;
      op_start = 1'b1;
      @(negedge clk);
      op_start = 1'b0;
      chk("busy and supply at start", 8'h03, {6'h00, busy, vpp_high});
      while (done !== 1'b1) @(negedge clk);
      chk("busy and supply at done", 8'h00, {6'h00, busy, vpp_high});
   endtask
   // about 70k cycles expected; the ceiling leaves some slack
   always @(posedge clk) begin
      cyc++;
      if (cyc == 100000) begin
         n_mismatch++;
         results();
      end
   end
   always @(negedge clk) if (rstn && we_n === 1'b0) begin
      chk("ce_n dq_oe vpp_high in write", 8'h03, {5'h00, ce_n, dq_oe, vpp_high});
   end
   initial begin
      foreach (ref_mem[i]) ref_mem[i] = 8'hFF;
      repeat (12) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      chk("idle strobes", 8'h07, {5'h00, ce_n, we_n, oe_n});
      e0 = erase_cnt;
      run(flash_host_pkg::OP_ERASE, 0, 8'h00);
      chk("erase pulses on blank part", 8'h00, 8'(erase_cnt - e0));
      run(flash_host_pkg::OP_IDENT, 0, 8'h00);
      chk("maker code", MAKER, rd_data);
      run(flash_host_pkg::OP_IDENT, 1, 8'h00);
      chk("part code", PART, rd_data);
      for (int i = 0; i < 2; i++) begin
         lfsr = lfsr_next(lfsr);
         a = 2 * i + 1;
         p0 = prog_cnt;
         run(flash_host_pkg::OP_PROG, a, lfsr[7:0]);
         chk("program pulses", (ref_mem[a] == lfsr[7:0]) ? 8'h01 : 8'h02,
            8'(prog_cnt - p0));
         chk("fail after program", 8'h00, {7'h00, fail});
         ref_mem[a] = ref_mem[a] & lfsr[7:0];
      end
      prog_need = 8'h1E;
      p0 = prog_cnt;
      run(flash_host_pkg::OP_PROG, 6, 8'h00);
      chk("pulses before giving up", 8'h19, 8'(prog_cnt - p0));
      chk("fail after limit", 8'h01, {7'h00, fail});
      p0 = prog_cnt;
      run(flash_host_pkg::OP_ABORT, 0, 8'h00);
      chk("pulses in abort", 8'h00, 8'(prog_cnt - p0));
      foreach (ref_mem[i]) begin
         run(flash_host_pkg::OP_READ, i, 8'h00);
         chk("array byte", 8'(ref_mem[i]), rd_data);
      end
      prog_need = 8'h01;
      p0 = prog_cnt;
      e0 = erase_cnt;
      run(flash_host_pkg::OP_ERASE, 0, 8'h00);
      chk("preprogram pulses", 8'h08, 8'(prog_cnt - p0));
      chk("erase pulses", 8'h02, 8'(erase_cnt - e0));
      foreach (ref_mem[i]) begin
         run(flash_host_pkg::OP_READ, i, 8'h00);
         chk("byte after erase", 8'hFF, rd_data);
      end
      results();
   end
endmodule
`default_nettype wire
